//--- src/host_config_map.svh
// register offsets, field positions, reset values and timing counts of the host configuration bank
`ifndef HOST_CONFIG_MAP_SVH
`define HOST_CONFIG_MAP_SVH

`define OFS_BANK_SELECT      4'hE
`define OFS_BASE_ADDR        4'h0
`define OFS_BURST_LENGTH     4'h8
`define OFS_STATION_LOW      4'h0
`define OFS_STATION_MIDDLE   4'h2
`define OFS_STATION_HIGH     4'h4
`define OFS_BUS_SPEED        4'h0
`define OFS_PROM_CONTROL     4'h2
`define OFS_SELFTEST         4'h4

`define BANK_BASE            6'h00
`define BANK_EMPTY           6'h01
`define BANK_STATION         6'h02
`define BANK_CONTROL         6'h03

`define BURST_LSB            12
`define BURST_MSB            14
`define PROM_SW_ACCESS_BIT   4
`define PROM_DATA_IN_BIT     3
`define TX_DONE_BIT          12
`define TX_FAIL_BIT          11
`define RX_DONE_BIT          4
`define RX_FAIL_BIT          3
`define CFG_SPEED_BIT        1

`define BURST_SINGLE         3'h0
`define BURST_FOUR           3'h3
`define BURST_EIGHT          3'h5
`define BURST_SIXTEEN        3'h7

`define SPEED_125MHZ         2'h0
`define SPEED_62P5MHZ        2'h1
`define SPEED_41P66MHZ       2'h2
`define SPEED_25MHZ          2'h3

`define BASE_ADDR_DEFAULT    16'h0300
`define BASE_ADDR_MASK       16'hFFE0

`define PROM_WORD_BASE       6'h00
`define PROM_WORD_LOW        6'h01
`define PROM_WORD_MIDDLE     6'h02
`define PROM_WORD_HIGH       6'h03
`define PROM_WORD_CONFIG     6'h06
`define PROM_READ_OPCODE     3'h6
`define PROM_LAST_INDEX      3'h4
`define PROM_CMD_BITS        5'h08
`define PROM_DATA_BITS       5'h10

`define SYS_CLK_NS           25
`define PROM_HALF_NS         1000
`define PROM_HALF_CYC        ((`PROM_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

//--- src/host_config_pkg.sv
// types shared by the host configuration bank and its serial prom loader
package host_config_pkg;
   typedef enum {LD_ARM, LD_CMD, LD_DATA, LD_GAP, LD_DONE} loader_state_t;
   typedef logic [5:0]  bank_t;
   typedef logic [15:0] word_t;
endpackage

//--- src/prom_loader.sv
// reset-time reader of the serial configuration prom, one read per word
`timescale 1ns/10ps
`include "host_config_map.svh"
module prom_loader (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_nrst,
   input  wire logic                  i_prom_present_pin,
   input  wire logic                  i_prom_data_in_pin,
   output logic                       o_cs,
   output logic                       o_sk,
   output logic                       o_do,
   output logic                       o_busy,
   output logic                       o_word_valid,
   output logic [5:0]                 o_word_addr,
   output host_config_pkg::word_t     o_word_data
);
   import host_config_pkg::*;

   localparam int HALF = `PROM_HALF_CYC;

   loader_state_t state;
   logic [6:0]    div;
   logic [4:0]    bitn;
   logic [2:0]    idx;
   logic [15:0]   shift;
   logic [8:0]    cmd;
   logic          tick;

   // fixed read order: base, three station words, then config word
   function automatic logic [5:0] word_of(input logic [2:0] i);
      case (i)
         3'h0:    word_of = `PROM_WORD_BASE;
         3'h1:    word_of = `PROM_WORD_LOW;
         3'h2:    word_of = `PROM_WORD_MIDDLE;
         3'h3:    word_of = `PROM_WORD_HIGH;
         default: word_of = `PROM_WORD_CONFIG;
      endcase
   endfunction

   assign tick        = (div == 7'(HALF - 1));
   assign cmd         = {`PROM_READ_OPCODE, word_of(idx)};
   assign o_word_addr = word_of(idx);
   assign o_busy      = (state != LD_DONE);

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst || tick || state == LD_ARM || state == LD_DONE) begin
         div <= 7'h00;
      end else begin
         div <= div + 7'h01;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         state        <= LD_ARM;
         o_cs         <= 1'b0;
         o_sk         <= 1'b0;
         o_do         <= 1'b0;
         bitn         <= 5'h00;
         idx          <= 3'h0;
         shift        <= 16'h0000;
         o_word_valid <= 1'b0;
         o_word_data  <= 16'h0000;
      end else begin
         o_word_valid <= 1'b0;
         unique case (state)
            LD_ARM: begin
               // strap sampled on the first edge after reset release
               if (i_prom_present_pin) begin
                  state <= LD_CMD;
                  o_cs  <= 1'b1;
                  o_do  <= cmd[8];
               end else begin
                  state <= LD_DONE;
               end
            end
            LD_CMD: if (tick) begin
               o_sk <= ~o_sk;
               if (o_sk) begin
                  if (bitn == `PROM_CMD_BITS) begin
                     state <= LD_DATA;
                     bitn  <= 5'h00;
                     o_do  <= 1'b0;
                  end else begin
                     bitn <= bitn + 5'h01;
                     o_do <= cmd[4'(4'h7 - bitn[3:0])];
                  end
               end
            end
            LD_DATA: if (tick) begin
               o_sk <= ~o_sk;
               if (!o_sk) begin
                  shift <= {shift[14:0], i_prom_data_in_pin};
               end else if (bitn == `PROM_DATA_BITS) begin
                  // leading dummy zero has shifted out of the top
                  state        <= LD_GAP;
                  o_cs         <= 1'b0;
                  o_word_valid <= 1'b1;
                  o_word_data  <= shift;
                  bitn         <= 5'h00;
               end else begin
                  bitn <= bitn + 5'h01;
               end
            end
            LD_GAP: if (tick) begin
               if (idx == `PROM_LAST_INDEX) begin
                  state <= LD_DONE;
               end else begin
                  idx   <= idx + 3'h1;
                  state <= LD_CMD;
                  o_cs  <= 1'b1;
                  o_do  <= 1'b1;
               end
            end
            LD_DONE: begin
               o_cs <= 1'b0;
               o_sk <= 1'b0;
               o_do <= 1'b0;
            end
         endcase
      end
   end
endmodule

//--- src/host_config_regs.sv
// banked host configuration and status registers with serial prom pin control
`timescale 1ns/10ps
`include "host_config_map.svh"
module host_config_regs (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_nrst,
   input  wire logic [3:0]            i_bus_addr,
   input  wire logic                  i_bus_wr,
   input  wire logic                  i_bus_rd,
   input  wire logic [1:0]            i_bus_be,
   input  wire host_config_pkg::word_t i_bus_wdata,
   output host_config_pkg::word_t     o_bus_rdata,
   input  wire logic                  i_prom_present_pin,
   input  wire logic                  i_prom_data_in_pin,
   output logic                       o_prom_data_out_pin,
   output logic                       o_prom_clock_pin,
   output logic                       o_prom_select_pin,
   output logic                       o_prom_loading,
   input  wire logic                  i_tx_selftest_done,
   input  wire logic                  i_tx_selftest_fail,
   input  wire logic                  i_rx_selftest_done,
   input  wire logic                  i_rx_selftest_fail,
   output host_config_pkg::bank_t     o_bank_select_field,
   output host_config_pkg::word_t     o_base_addr,
   output logic [2:0]                 o_burst_len_code,
   output logic [4:0]                 o_burst_beats,
   output logic [1:0]                 o_bus_speed_select,
   output logic [47:0]                o_station_addr
);
   import host_config_pkg::*;

   bank_t       bank_select_field;
   word_t       base_addr;
   logic [2:0]  burst_len_code;
   word_t       station_addr_low;
   word_t       station_addr_middle;
   word_t       station_addr_high;
   logic [1:0]  bus_speed_select;
   logic        prom_software_access;
   logic [2:0]  prom_pin_bits;
   word_t       next_rdata;

   logic        ld_cs;
   logic        ld_sk;
   logic        ld_do;
   logic        ld_valid;
   logic [5:0]  ld_addr;
   word_t       ld_data;

   prom_loader u_loader (
      .i_sys_clk          (i_sys_clk),
      .i_nrst             (i_nrst),
      .i_prom_present_pin (i_prom_present_pin),
      .i_prom_data_in_pin (i_prom_data_in_pin),
      .o_cs               (ld_cs),
      .o_sk               (ld_sk),
      .o_do               (ld_do),
      .o_busy             (o_prom_loading),
      .o_word_valid       (ld_valid),
      .o_word_addr        (ld_addr),
      .o_word_data        (ld_data)
   );

   // byte-lane merge; the address bus carries byte offsets, bit 0 ignored
   function automatic word_t merge(input word_t old, input word_t wd, input logic [1:0] be);
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic hit(input bank_t bank, input logic [3:0] ofs);
      hit = i_bus_wr && (bank_select_field == bank) && (i_bus_addr[3:1] == ofs[3:1]);
   endfunction

   // beats per burst; unlisted codes fall back to single transfers
   function automatic logic [4:0] beats_of(input logic [2:0] code);
      case (code)
         `BURST_FOUR:    beats_of = 5'h04;
         `BURST_EIGHT:   beats_of = 5'h08;
         `BURST_SIXTEEN: beats_of = 5'h10;
         default:        beats_of = 5'h01;
      endcase
   endfunction

   // bank select sits at the same offset in every bank
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         bank_select_field <= 6'h00;
      end else if (i_bus_wr && i_bus_addr[3:1] == `OFS_BANK_SELECT >> 1 && i_bus_be[0]) begin
         bank_select_field <= i_bus_wdata[5:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         base_addr <= `BASE_ADDR_DEFAULT;
      end else if (ld_valid && ld_addr == `PROM_WORD_BASE) begin
         base_addr <= ld_data & `BASE_ADDR_MASK;
      end else if (hit(`BANK_BASE, `OFS_BASE_ADDR)) begin
         base_addr <= merge(base_addr, i_bus_wdata, i_bus_be) & `BASE_ADDR_MASK;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         burst_len_code <= `BURST_SINGLE;
      end else if (hit(`BANK_BASE, `OFS_BURST_LENGTH) && i_bus_be[1]) begin
         burst_len_code <= i_bus_wdata[`BURST_MSB:`BURST_LSB];
      end
   end

   // loader words win over a host write in the same cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         station_addr_low    <= 16'h0000;
         station_addr_middle <= 16'h0000;
         station_addr_high   <= 16'h0000;
      end else begin
         if (ld_valid && ld_addr == `PROM_WORD_LOW) begin
            station_addr_low <= ld_data;
         end else if (hit(`BANK_STATION, `OFS_STATION_LOW)) begin
            station_addr_low <= merge(station_addr_low, i_bus_wdata, i_bus_be);
         end
         if (ld_valid && ld_addr == `PROM_WORD_MIDDLE) begin
            station_addr_middle <= ld_data;
         end else if (hit(`BANK_STATION, `OFS_STATION_MIDDLE)) begin
            station_addr_middle <= merge(station_addr_middle, i_bus_wdata, i_bus_be);
         end
         if (ld_valid && ld_addr == `PROM_WORD_HIGH) begin
            station_addr_high <= ld_data;
         end else if (hit(`BANK_STATION, `OFS_STATION_HIGH)) begin
            station_addr_high <= merge(station_addr_high, i_bus_wdata, i_bus_be);
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         bus_speed_select <= `SPEED_125MHZ;
      end else if (ld_valid && ld_addr == `PROM_WORD_CONFIG) begin
         bus_speed_select <= ld_data[`CFG_SPEED_BIT] ? `SPEED_25MHZ : `SPEED_125MHZ;
      end else if (hit(`BANK_CONTROL, `OFS_BUS_SPEED) && i_bus_be[0]) begin
         bus_speed_select <= i_bus_wdata[1:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         prom_software_access <= 1'b0;
         prom_pin_bits        <= 3'h0;
      end else if (hit(`BANK_CONTROL, `OFS_PROM_CONTROL) && i_bus_be[0]) begin
         prom_software_access <= i_bus_wdata[`PROM_SW_ACCESS_BIT];
         prom_pin_bits        <= i_bus_wdata[2:0];
      end
   end

   // software owns the pins only when granted; a grant during loading corrupts that read
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_prom_data_out_pin <= 1'b0;
         o_prom_clock_pin    <= 1'b0;
         o_prom_select_pin   <= 1'b0;
      end else if (prom_software_access) begin
         o_prom_data_out_pin <= prom_pin_bits[2];
         o_prom_clock_pin    <= prom_pin_bits[1];
         o_prom_select_pin   <= prom_pin_bits[0];
      end else begin
         o_prom_data_out_pin <= ld_do;
         o_prom_clock_pin    <= ld_sk;
         o_prom_select_pin   <= ld_cs;
      end
   end

   // read mux; everything not listed reads zero
   always_comb begin
      next_rdata = 16'h0000;
      if (i_bus_addr[3:1] == `OFS_BANK_SELECT >> 1) begin
         next_rdata[5:0] = bank_select_field;
      end else begin
         unique case (bank_select_field)
            `BANK_BASE: begin
               if (i_bus_addr[3:1] == `OFS_BASE_ADDR >> 1) begin
                  next_rdata = base_addr;
               end else if (i_bus_addr[3:1] == `OFS_BURST_LENGTH >> 1) begin
                  next_rdata[`BURST_MSB:`BURST_LSB] = burst_len_code;
               end
            end
            `BANK_STATION: begin
               if (i_bus_addr[3:1] == `OFS_STATION_LOW >> 1) begin
                  next_rdata = station_addr_low;
               end else if (i_bus_addr[3:1] == `OFS_STATION_MIDDLE >> 1) begin
                  next_rdata = station_addr_middle;
               end else if (i_bus_addr[3:1] == `OFS_STATION_HIGH >> 1) begin
                  next_rdata = station_addr_high;
               end
            end
            `BANK_CONTROL: begin
               if (i_bus_addr[3:1] == `OFS_BUS_SPEED >> 1) begin
                  next_rdata[1:0] = bus_speed_select;
               end else if (i_bus_addr[3:1] == `OFS_PROM_CONTROL >> 1) begin
                  next_rdata[`PROM_SW_ACCESS_BIT] = prom_software_access;
                  next_rdata[`PROM_DATA_IN_BIT]   = i_prom_data_in_pin;
                  next_rdata[2:0]                 = prom_pin_bits;
               end else if (i_bus_addr[3:1] == `OFS_SELFTEST >> 1) begin
                  next_rdata[`TX_DONE_BIT] = i_tx_selftest_done;
                  next_rdata[`TX_FAIL_BIT] = i_tx_selftest_fail;
                  next_rdata[`RX_DONE_BIT] = i_rx_selftest_done;
                  next_rdata[`RX_FAIL_BIT] = i_rx_selftest_fail;
               end
            end
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_bus_rdata <= 16'h0000;
      end else if (i_bus_rd) begin
         o_bus_rdata <= next_rdata;
      end
   end

   assign o_bank_select_field = bank_select_field;
   assign o_base_addr         = base_addr;
   assign o_burst_len_code    = burst_len_code;
   assign o_burst_beats       = beats_of(burst_len_code);
   assign o_bus_speed_select  = bus_speed_select;
   assign o_station_addr      = {station_addr_high, station_addr_middle, station_addr_low};
endmodule

//--- sim/prom_model.sv
// behavioural serial configuration prom answering one word read per select
`timescale 1ns/10ps
module prom_model
   import host_config_pkg::*;
(
   input  wire logic   i_cs,
   input  wire logic   i_sk,
   input  wire logic   i_do,
   input  wire word_t  i_mem [0:7],
   output logic        o_di
);
   int         cnt;
   logic [5:0] adr;
   word_t      sh;
   initial begin
      o_di = 1'b0;
      cnt = 0;
      adr = 6'h00;
   end
   // start and opcode bits pass, six address bits follow
   always @(posedge i_sk) begin
      if (i_cs) begin
         if (cnt >= 3 && cnt < 9) adr = {adr[4:0], i_do};
         cnt = cnt + 1;
      end
   end
   // contents are never written: host edits stay inside the device
   always @(negedge i_sk) begin
      if (i_cs && cnt == 9) begin
         sh = i_mem[adr[2:0]];
         o_di = 1'b0;
      end else if (i_cs && cnt > 9) begin
         o_di = sh[15];
         sh = sh << 1;
      end
   end
   // released line does not keep its last level
   always @(negedge i_cs) begin
      cnt = 0;
      o_di = ~o_di;
   end
endmodule

//--- sim/host_config_regs_chk.sv
// concurrent checks on the host configuration bank ports
`timescale 1ns/10ps
module host_config_regs_chk (
   input wire logic                   i_sys_clk,
   input wire logic                   i_nrst,
   input wire logic [3:0]             i_bus_addr,
   input wire logic                   i_bus_wr,
   input wire logic                   i_bus_rd,
   input wire logic [1:0]             i_bus_be,
   input wire host_config_pkg::word_t i_bus_wdata,
   input wire host_config_pkg::word_t o_bus_rdata,
   input wire logic                   o_prom_loading,
   input wire logic                   o_prom_data_out_pin,
   input wire logic                   o_prom_clock_pin,
   input wire logic                   o_prom_select_pin,
   input wire logic                   i_tx_selftest_done,
   input wire logic                   i_tx_selftest_fail,
   input wire logic                   i_rx_selftest_done,
   input wire logic                   i_rx_selftest_fail,
   input wire host_config_pkg::bank_t o_bank_select_field,
   input wire host_config_pkg::word_t o_base_addr,
   input wire logic [2:0]             o_burst_len_code,
   input wire logic [4:0]             o_burst_beats,
   input wire logic [1:0]             o_bus_speed_select
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   wire logic [2:0] wa = i_bus_addr[3:1];
   wire logic       b3 = o_bank_select_field == 6'h03;
   a_reset_values: assert property ($rose(i_nrst) |-> o_bank_select_field == 6'h00 && o_burst_len_code == 3'h0
      && o_bus_speed_select == 2'h0 && o_base_addr == 16'h0300) else $error("values after reset wrong");
   a_bank_write: assert property (i_bus_wr && wa == 3'h7 && i_bus_be[0]
      |=> o_bank_select_field == $past(i_bus_wdata[5:0])) else $error("bank select not written");
   a_burst_write: assert property (i_bus_wr && o_bank_select_field == 6'h00 && wa == 3'h4 && i_bus_be[1]
      |=> o_burst_len_code == $past(i_bus_wdata[14:12])) else $error("burst code not written");
   a_burst_decode: assert property (o_burst_beats == ((o_burst_len_code == 3'h3) ? 5'h04 :
      (o_burst_len_code == 3'h5) ? 5'h08 : (o_burst_len_code == 3'h7) ? 5'h10 : 5'h01)) else $error("beat decode");
   a_speed_write: assert property (i_bus_wr && b3 && wa == 3'h0 && i_bus_be[0] && !o_prom_loading
      |=> o_bus_speed_select == $past(i_bus_wdata[1:0])) else $error("speed not written");
   a_pin_follow: assert property (i_bus_wr && b3 && wa == 3'h1 && i_bus_be[0] && i_bus_wdata[4] |-> ##2
      {o_prom_data_out_pin, o_prom_clock_pin, o_prom_select_pin} == $past(i_bus_wdata[2:0], 2)) else $error("pins");
   a_selftest_read: assert property (i_bus_rd && b3 && wa == 3'h2 |=> o_bus_rdata == {3'h0,
      $past(i_tx_selftest_done), $past(i_tx_selftest_fail), 6'h00, $past(i_rx_selftest_done),
      $past(i_rx_selftest_fail), 3'h0}) else $error("self-test word wrong");
   a_bank1_zero: assert property (i_bus_rd && o_bank_select_field == 6'h01 && wa != 3'h7
      |=> o_bus_rdata == 16'h0000) else $error("empty bank read not zero");
   a_base_reserved: assert property (o_base_addr[4:0] == 5'h00) else $error("base low bits set");
   a_rdata_hold: assert property (!i_bus_rd |=> $stable(o_bus_rdata)) else $error("read data moved");
   c_load_done: cover property ($fell(o_prom_loading));
   c_pin_drive: cover property (i_bus_wr && b3 && wa == 3'h1 && i_bus_wdata[4]);
   c_empty_read: cover property (i_bus_rd && o_bank_select_field == 6'h01);
endmodule
bind host_config_regs host_config_regs_chk host_config_regs_chk_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
   .i_bus_addr(i_bus_addr), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .i_bus_be(i_bus_be),
   .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata), .o_prom_loading(o_prom_loading),
   .o_prom_data_out_pin(o_prom_data_out_pin), .o_prom_clock_pin(o_prom_clock_pin),
   .o_prom_select_pin(o_prom_select_pin), .i_tx_selftest_done(i_tx_selftest_done),
   .i_tx_selftest_fail(i_tx_selftest_fail), .i_rx_selftest_done(i_rx_selftest_done),
   .i_rx_selftest_fail(i_rx_selftest_fail), .o_bank_select_field(o_bank_select_field),
   .o_base_addr(o_base_addr), .o_burst_len_code(o_burst_len_code), .o_burst_beats(o_burst_beats),
   .o_bus_speed_select(o_bus_speed_select));

//--- sim/test_host_config_regs.sv
// self-checking bench for the host configuration bank with a bus-side reference model
`timescale 1ns/10ps
module test_host_config_regs;
   import host_config_pkg::*;
   logic        clk, nrst, wr, rd, strap, tb_din, use_model, tx_d, tx_f, rx_d, rx_f;
   logic        dout, sk, cs, loading, model_di;
   logic [3:0]  addr;
   logic [1:0]  be, speed;
   logic [2:0]  burst;
   logic [4:0]  beats;
   logic [47:0] station;
   word_t       wdata, rdata, base;
   bank_t       bank;
   word_t       mem [0:7];
   int          errors, n_compared, cyc, bsel;
   int          m [0:63];
   int          wm [0:63];
   int          codes [4] = '{0, 3, 5, 7};
   int unsigned seed = 87;
   wire logic   prom_di = use_model ? model_di : tb_din;

   host_config_regs host_config_regs_inst (.i_sys_clk(clk), .i_nrst(nrst), .i_bus_addr(addr), .i_bus_wr(wr),
      .i_bus_rd(rd), .i_bus_be(be), .i_bus_wdata(wdata), .o_bus_rdata(rdata), .i_prom_present_pin(strap),
      .i_prom_data_in_pin(prom_di), .o_prom_data_out_pin(dout), .o_prom_clock_pin(sk),
      .o_prom_select_pin(cs), .o_prom_loading(loading), .i_tx_selftest_done(tx_d),
      .i_tx_selftest_fail(tx_f), .i_rx_selftest_done(rx_d), .i_rx_selftest_fail(rx_f),
      .o_bank_select_field(bank), .o_base_addr(base), .o_burst_len_code(burst), .o_burst_beats(beats),
      .o_bus_speed_select(speed), .o_station_addr(station));
   prom_model prom_model_inst (.i_cs(cs), .i_sk(sk), .i_do(dout), .i_mem(mem), .o_di(model_di));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         final_report();
      end
   end
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic final_report();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // reference model: index is bank*8 + word offset, wm marks writable bits
   task automatic mdl_reset(input logic ld);
      foreach (m[i]) begin
         m[i] = 0;
         wm[i] = 0;
      end
      bsel = 0;
      m[0] = 16'h0300;
      wm[0] = 16'hFFE0;
      wm[4] = 16'h7000;
      wm[16] = 16'hFFFF;
      wm[17] = 16'hFFFF;
      wm[18] = 16'hFFFF;
      wm[24] = 16'h0003;
      wm[25] = 16'h0017;
      if (ld) begin
         m[0] = mem[0] & 16'hFFE0;
         m[16] = mem[1];
         m[17] = mem[2];
         m[18] = mem[3];
         m[24] = mem[6][1] ? 3 : 0;
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input int d, input logic [1:0] b);
      int mk;
      int k;
      mk = (b[1] ? 16'hFF00 : 0) | (b[0] ? 16'h00FF : 0);
      k = bsel * 8 + a / 2;
      @(posedge clk);
      #2;
      addr = a;
      wdata = d[15:0];
      be = b;
      wr = 1'b1;
      @(posedge clk);
      #2;
      wr = 1'b0;
      if (a[3:1] == 3'h7) begin
         if (b[0]) bsel = d & 63;
      end else if (bsel < 5) m[k] = (m[k] & ~(mk & wm[k])) | (d & mk & wm[k]);
   endtask
   function automatic int exp_rd(input logic [3:0] a);
      if (a[3:1] == 3'h7) return bsel;
      if (bsel == 3 && a[3:1] == 3'h1) return m[25] | (int'(prom_di) << 3);
      if (bsel == 3 && a[3:1] == 3'h2) return (tx_d << 12) | (tx_f << 11) | (rx_d << 4) | (rx_f << 3);
      if (bsel < 5) return m[bsel * 8 + a / 2];
      return 0;
   endfunction
   task automatic rd_chk(input logic [3:0] a);
      int e;
      e = exp_rd(a);
      @(posedge clk);
      #2;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #2;
      rd = 1'b0;
      chk("rdata", rdata, e);
   endtask
   task automatic chk_outs();
      int c;
      c = m[4] >> 12;
      chk("bank", bank, bsel);
      chk("base", base, m[0]);
      chk("burst", burst, c);
      chk("beats", beats, c == 3 ? 4 : c == 5 ? 8 : c == 7 ? 16 : 1);
      chk("speed", speed, m[24]);
      chk("station", station, {m[18][15:0], m[17][15:0], m[16][15:0]});
   endtask
   task automatic do_reset(input logic s);
      @(posedge clk);
      #2;
      nrst = 1'b0;
      strap = s;
      use_model = s;
      repeat (8) @(posedge clk);
      #2;
      nrst = 1'b1;
      chk("loading", loading, 1);
      for (int k = 0; k < 20000 && loading !== 1'b0; k++) @(posedge clk);
      #2;
      chk("loading", loading, 0);
      mdl_reset(s);
   endtask

   initial begin
      {nrst, wr, rd, strap, tb_din, use_model, tx_d, tx_f, rx_d, rx_f} = '0;
      addr = 4'h0;
      be = 2'h0;
      wdata = 16'h0000;
      foreach (mem[i]) mem[i] = 16'h0000;
      do_reset(1'b0);
      chk_outs();
      for (int bk = 0; bk < 5; bk++) begin
         wr_reg(4'hE, bk, 2'h1);
         rd_chk(4'hE);
         for (int a = 0; a < 14; a += 2) begin
            wr_reg(a[3:0], xs(), 2'(xs() % 3 + 1));
            rd_chk(a[3:0]);
         end
      end
      chk_outs();
      wr_reg(4'hE, 0, 2'h1);
      foreach (codes[i]) begin
         wr_reg(4'h8, (codes[i] << 12) | (xs() & 16'h8FFF), 2'h2);
         chk_outs();
         rd_chk(4'h8);
      end
      wr_reg(4'hE, 3, 2'h1);
      for (int s = 0; s < 4; s++) begin
         wr_reg(4'h0, s | (xs() & 16'hFFFC), 2'h3);
         chk_outs();
      end
      for (int i = 0; i < 8; i++) begin
         tb_din = xs() & 1;
         wr_reg(4'h2, (xs() & 16'hFFE8) | 16'h0010 | i, 2'h1);
         @(posedge clk);
         #2;
         chk("pins", {dout, sk, cs}, i);
         rd_chk(4'h2);
      end
      // access withdrawn: the idle loader keeps the pins low
      wr_reg(4'h2, 16'h0007, 2'h1);
      @(posedge clk);
      #2;
      chk("pins", {dout, sk, cs}, 0);
      for (int i = 0; i < 4; i++) begin
         {tx_d, tx_f, rx_d, rx_f} = 4'(xs());
         rd_chk(4'h4);
      end
      foreach (mem[i]) mem[i] = xs();
      mem[6][1] = 1'b1;
      do_reset(1'b1);
      chk_outs();
      wr_reg(4'hE, 2, 2'h1);
      for (int a = 0; a < 6; a += 2) rd_chk(a[3:0]);
      wr_reg(4'h0, xs(), 2'h3);
      wr_reg(4'hE, 3, 2'h1);
      wr_reg(4'h0, 1, 2'h1);
      chk_outs();
      final_report();
   end
endmodule
